// ===== hdl/dph_pkg.sv
// Shared constants, types and state layout of the half-rate PHY handshake block
package dph_pkg;
    localparam int DQ_W = 8;
    localparam int DM_W = 1;
    localparam int AW = 14;
    localparam int BW = 3;
    localparam int RANKS = 2;
    localparam int RK_W = 1;
    localparam int LAT_W = 5;
    localparam int DL_DEPTH = 32;
    localparam int CNT_W = 8;
    localparam int INIT_W = 12;

    localparam int CLK_MHZ = 200;
    // Memory power-up wait, no figure given, plain default
    localparam int INIT_TIME_NS = 10000;
    localparam int INIT_CYC = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
    // Longest wait for a calibration read strobe
    localparam int CAL_TIMEOUT_NS = 300;
    localparam int CAL_TO_CYC = (CAL_TIMEOUT_NS * CLK_MHZ) / 1000;

    localparam logic [INIT_W-1:0] INIT_END = INIT_W'(INIT_CYC - 1);
    localparam logic [INIT_W-1:0] INIT_RST_END = INIT_W'(INIT_CYC / 2);
    localparam logic [CNT_W-1:0] CAL_TO_LAST = CNT_W'(CAL_TO_CYC - 1);
    localparam logic [LAT_W-1:0] RLAT_ADD = 5'h01;
    localparam logic [LAT_W-1:0] WLAT_BASE = 5'h02;
    localparam logic [1:0] DQS_PATTERN = 2'h1;
    localparam logic [RK_W-1:0] RANK_LAST = RK_W'(RANKS - 1);

    typedef struct packed {
        logic [RANKS-1:0] cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [AW-1:0] addr;
        logic [BW-1:0] ba;
    } dph_cmd_t;

    localparam dph_cmd_t CMD_IDLE = '{cs_n: {RANKS{1'b1}}, ras_n: 1'b1, cas_n: 1'b1,
                                      we_n: 1'b1, addr: {AW{1'b0}}, ba: {BW{1'b0}}};

    typedef enum logic [5:0] {
        SEQ_HOLD = 6'h01,
        SEQ_INIT = 6'h02,
        SEQ_CAL_RD = 6'h04,
        SEQ_CAL_WAIT = 6'h08,
        SEQ_DONE = 6'h10,
        SEQ_FAIL = 6'h20
    } dph_seq_t;

    typedef struct packed {
        logic [2:0] rs;
        logic ph;
        dph_seq_t seq;
        logic [INIT_W-1:0] init_cnt;
        logic [RK_W-1:0] rank;
        logic [CNT_W-1:0] cal_cnt;
        logic [CNT_W-1:0] cal_max;
        logic [LAT_W-1:0] rlat;
        logic [LAT_W-1:0] wlat;
        logic cal_ok;
        logic cal_bad;
        logic rst_out;
        logic mrst_n;
        logic cke;
        dph_cmd_t cmd;
        dph_cmd_t cmd_hi;
        logic [2*DQ_W-1:0] dq_out;
        logic [2*DQ_W-1:0] dq_hi;
        logic dq_oe;
        logic dq_oe_hi;
        logic dqs_oe;
        logic dqs_oe_hi;
        logic [2*DM_W-1:0] dm;
        logic [2*DM_W-1:0] dm_hi;
        logic rt;
        logic rt_hi;
        logic gate;
        logic gate_hi;
        logic [2*DQ_W-1:0] dq_s1;
        logic [2*DQ_W-1:0] dq_s2;
        logic [2*DQ_W-1:0] dq_s3;
        logic [2*DQ_W-1:0] dq_stab;
        logic dqs_s1;
        logic dqs_s2;
        logic dqs_s3;
        logic dqs_stab;
        logic [2*DQ_W-1:0] rd_lo;
        logic [4*DQ_W-1:0] rdata;
        logic [1:0] rvalid;
        logic [DL_DEPTH-1:0][1:0] dl;
        logic [LAT_W-1:0] wp;
    } dph_state_t;
endpackage : dph_pkg

// ===== hdl/dph_phy_handshake.sv
// Half-rate PHY handshake: reset, calibration, command and data serialisation
// Operation
// - Interface clock at half memory rate; all user ports sync to it. Calibration status, latencies and soft reset act on every memory cycle instead.
// - Global reset released freely by user; resynchronised internally before use.
// - Active-low user reset output deasserts synchronously to the interface clock.
// - After reset the device initialises memory and calibrates by reading each rank.
// - Calibration end raises success if passed, otherwise raises failure.
// - Soft reset holds sequencer in reset; release restarts full calibration.
// - Half-rate local data buses are four times the memory data width.
// - Command inputs sized for 1T: two input bits per memory pin at half rate.
// - Read-in-progress drives postamble gating, read-valid generation and termination timing.
// - Device reports read latency from read-in-progress to valid read data.
// - Read latency valid after successful calibration and constant afterward.
// - Read-valid output is two bits at half rate for unaligned data.
// - Device reports write latency from chip select to strobe burst.
// - Write latency valid after calibration success, never changes afterward.
// - Two-bit chip select and strobe inputs leave LSB first, MSB next.
// - Address bus is two concatenated halves, one per memory cycle, low half first.
module dph_phy_handshake
    import dph_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic soft_reset_n,
    output logic ctl_clk,
    output logic ctl_clk_en,
    output logic ctl_reset_n,
    output logic ctl_cal_success,
    output logic ctl_cal_fail,
    output logic [LAT_W-1:0] ctl_rlat,
    output logic [LAT_W-1:0] ctl_wlat,
    input wire logic [2*RANKS-1:0] ctl_cs_n,
    input wire logic [1:0] ctl_ras_n,
    input wire logic [1:0] ctl_cas_n,
    input wire logic [1:0] ctl_we_n,
    input wire logic [2*AW-1:0] ctl_addr,
    input wire logic [2*BW-1:0] ctl_ba,
    input wire logic [1:0] ctl_doing_read,
    input wire logic [1:0] ctl_dqs_burst,
    input wire logic [1:0] ctl_wdata_valid,
    input wire logic [4*DQ_W-1:0] ctl_wdata,
    input wire logic [4*DM_W-1:0] ctl_dm,
    output logic [4*DQ_W-1:0] ctl_rdata,
    output logic [1:0] ctl_rdata_valid,
    output dph_cmd_t mem_cmd,
    output logic mem_reset_n,
    output logic mem_cke,
    output logic [2*DQ_W-1:0] mem_dq_out,
    output logic mem_dq_oe,
    input wire logic [2*DQ_W-1:0] mem_dq_in,
    output logic [1:0] mem_dqs_out,
    output logic mem_dqs_oe,
    input wire logic mem_dqs_in,
    output logic [2*DM_W-1:0] data_mask_pins,
    output logic mem_rt_en,
    output logic mem_dqs_gate
);
    dph_state_t st;
    dph_state_t next_st;
    dph_cmd_t cmd_lo_in;
    dph_cmd_t cmd_hi_in;
    dph_cmd_t cal_read;
    logic [1:0] dl_tap;
    logic [LAT_W-1:0] tap_idx;
    logic [CNT_W-1:0] cal_worst;
    logic [LAT_W-1:0] cal_rlat;

    // Memory-cycle halves of the 1T command inputs, low half goes first
    always_comb begin
        cmd_lo_in.cs_n = '0;
        cmd_hi_in.cs_n = '0;
        for (int r = 0; r < RANKS; r++) begin
            cmd_lo_in.cs_n[r] = ctl_cs_n[2*r];
            cmd_hi_in.cs_n[r] = ctl_cs_n[2*r+1];
        end
        cmd_lo_in.ras_n = ctl_ras_n[0];
        cmd_hi_in.ras_n = ctl_ras_n[1];
        cmd_lo_in.cas_n = ctl_cas_n[0];
        cmd_hi_in.cas_n = ctl_cas_n[1];
        cmd_lo_in.we_n = ctl_we_n[0];
        cmd_hi_in.we_n = ctl_we_n[1];
        cmd_lo_in.addr = ctl_addr[AW-1:0];
        cmd_hi_in.addr = ctl_addr[2*AW-1:AW];
        cmd_lo_in.ba = ctl_ba[BW-1:0];
        cmd_hi_in.ba = ctl_ba[2*BW-1:BW];
        cal_read = CMD_IDLE;
        cal_read.cs_n = ~(RANKS'(1) << st.rank);
        cal_read.cas_n = 1'b0;
    end

    assign tap_idx = st.wp - st.rlat;
    assign dl_tap = st.dl[tap_idx];

    // Worst rank count so far, the answering rank included
    always_comb begin
        cal_worst = st.cal_max;
        if (st.cal_cnt > st.cal_max) begin
            cal_worst = st.cal_cnt;
        end
        cal_rlat = LAT_W'(cal_worst >> 1) + RLAT_ADD;
    end

    always_comb begin
        next_st = st;
        // Pin inputs: three stages, accept only when stages two and three agree
        next_st.dq_s1 = mem_dq_in;
        next_st.dq_s2 = st.dq_s1;
        next_st.dq_s3 = st.dq_s2;
        // Per-bit filter, so one noisy lane cannot hold back the others
        for (int b = 0; b < 2*DQ_W; b++) begin
            if (st.dq_s2[b] == st.dq_s3[b]) begin
                next_st.dq_stab[b] = st.dq_s3[b];
            end
        end
        next_st.dqs_s1 = mem_dqs_in;
        next_st.dqs_s2 = st.dqs_s1;
        next_st.dqs_s3 = st.dqs_s2;
        if (st.dqs_s2 == st.dqs_s3) begin
            next_st.dqs_stab = st.dqs_s3;
        end
        next_st.rs = {st.rs[1:0], 1'b1};
        next_st.ph = ~st.ph;
        if (st.ph) begin
            next_st.rst_out = 1'b1;
        end

        case (st.seq)
            SEQ_HOLD: begin
                next_st.cmd = CMD_IDLE;
                next_st.rank = '0;
                next_st.cal_max = '0;
                if (soft_reset_n) begin
                    next_st.seq = st.cke ? SEQ_CAL_RD : SEQ_INIT;
                end
            end
            SEQ_INIT: begin
                next_st.init_cnt = st.init_cnt + 1'b1;
                if (st.init_cnt == INIT_RST_END) begin
                    next_st.mrst_n = 1'b1;
                end
                if (st.init_cnt == INIT_END) begin
                    next_st.cke = 1'b1;
                    next_st.seq = SEQ_CAL_RD;
                end
            end
            SEQ_CAL_RD: begin
                next_st.cmd = cal_read;
                next_st.cal_cnt = '0;
                next_st.seq = SEQ_CAL_WAIT;
            end
            SEQ_CAL_WAIT: begin
                next_st.cmd = CMD_IDLE;
                next_st.cal_cnt = st.cal_cnt + 1'b1;
                if (st.dqs_stab) begin
                    next_st.cal_max = cal_worst;
                    if (st.rank == RANK_LAST) begin
                        // Slowest rank sets the common latency
                        next_st.rlat = cal_rlat;
                        next_st.wlat = WLAT_BASE;
                        next_st.cal_ok = 1'b1;
                        next_st.seq = SEQ_DONE;
                    end else begin
                        next_st.rank = st.rank + 1'b1;
                        next_st.seq = SEQ_CAL_RD;
                    end
                end else if (st.cal_cnt == CAL_TO_LAST) begin
                    next_st.cal_bad = 1'b1;
                    next_st.seq = SEQ_FAIL;
                end
            end
            SEQ_DONE: begin
                // Latencies are left untouched here until the next recalibration
                if (st.ph) begin
                    next_st.cmd = cmd_lo_in;
                    next_st.cmd_hi = cmd_hi_in;
                    next_st.dq_out = ctl_wdata[2*DQ_W-1:0];
                    next_st.dq_hi = ctl_wdata[4*DQ_W-1:2*DQ_W];
                    next_st.dq_oe = ctl_wdata_valid[0];
                    next_st.dq_oe_hi = ctl_wdata_valid[1];
                    next_st.dqs_oe = ctl_dqs_burst[0];
                    next_st.dqs_oe_hi = ctl_dqs_burst[1];
                    next_st.dm = ctl_dm[2*DM_W-1:0];
                    next_st.dm_hi = ctl_dm[4*DM_W-1:2*DM_W];
                    next_st.rt = ctl_doing_read[0];
                    next_st.rt_hi = ctl_doing_read[1];
                    next_st.dl[st.wp] = ctl_doing_read;
                    next_st.wp = st.wp + 1'b1;
                    next_st.rvalid = dl_tap;
                    next_st.gate = dl_tap[0];
                    next_st.gate_hi = dl_tap[1];
                    next_st.rdata = {st.dq_stab, st.rd_lo};
                end else begin
                    next_st.cmd = st.cmd_hi;
                    next_st.dq_out = st.dq_hi;
                    next_st.dq_oe = st.dq_oe_hi;
                    next_st.dqs_oe = st.dqs_oe_hi;
                    next_st.dm = st.dm_hi;
                    next_st.rt = st.rt_hi;
                    next_st.gate = st.gate_hi;
                    next_st.rd_lo = st.dq_stab;
                end
            end
            SEQ_FAIL: begin
                next_st.cmd = CMD_IDLE;
            end
            default: begin
                next_st.seq = SEQ_HOLD;
            end
        endcase

        // Recalibration drops the datapath and both status flags
        if (!soft_reset_n) begin
            next_st.seq = SEQ_HOLD;
            next_st.cal_ok = 1'b0;
            next_st.cal_bad = 1'b0;
            next_st.cmd = CMD_IDLE;
            next_st.dq_oe = 1'b0;
            next_st.dqs_oe = 1'b0;
            next_st.rt = 1'b0;
            next_st.gate = 1'b0;
            next_st.rvalid = 2'h0;
            next_st.dl = '0;
            // Stale second halves would replay an old command after recalibration
            next_st.cmd_hi = CMD_IDLE;
            next_st.dq_oe_hi = 1'b0;
            next_st.dqs_oe_hi = 1'b0;
            next_st.rt_hi = 1'b0;
            next_st.gate_hi = 1'b0;
            // Memory init cut short starts again from its first cycle
            if (!st.cke) begin
                next_st.init_cnt = '0;
            end
        end

        // Internal reset lasts until the release has crossed the chain
        if (!rst_n || !st.rs[2]) begin
            next_st.ph = 1'b0;
            next_st.seq = SEQ_HOLD;
            next_st.init_cnt = '0;
            next_st.rank = '0;
            next_st.cal_cnt = '0;
            next_st.cal_max = '0;
            next_st.rlat = '0;
            next_st.wlat = '0;
            next_st.cal_ok = 1'b0;
            next_st.cal_bad = 1'b0;
            next_st.rst_out = 1'b0;
            next_st.mrst_n = 1'b0;
            next_st.cke = 1'b0;
            next_st.cmd = CMD_IDLE;
            next_st.cmd_hi = CMD_IDLE;
            next_st.dq_out = '0;
            next_st.dq_hi = '0;
            next_st.dq_oe = 1'b0;
            next_st.dq_oe_hi = 1'b0;
            next_st.dqs_oe = 1'b0;
            next_st.dqs_oe_hi = 1'b0;
            next_st.dm = '0;
            next_st.dm_hi = '0;
            next_st.rt = 1'b0;
            next_st.rt_hi = 1'b0;
            next_st.gate = 1'b0;
            next_st.gate_hi = 1'b0;
            next_st.rd_lo = '0;
            next_st.rdata = '0;
            next_st.rvalid = 2'h0;
            next_st.dl = '0;
            next_st.wp = '0;
        end
        if (!rst_n) begin
            next_st.rs = 3'h0;
            next_st.dq_s1 = '0;
            next_st.dq_s2 = '0;
            next_st.dq_s3 = '0;
            next_st.dq_stab = '0;
            next_st.dqs_s1 = 1'b0;
            next_st.dqs_s2 = 1'b0;
            next_st.dqs_s3 = 1'b0;
            next_st.dqs_stab = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    assign ctl_clk = st.ph;
    assign ctl_clk_en = st.ph;
    assign ctl_reset_n = st.rst_out;
    assign ctl_cal_success = st.cal_ok;
    assign ctl_cal_fail = st.cal_bad;
    assign ctl_rlat = st.rlat;
    assign ctl_wlat = st.wlat;
    assign ctl_rdata = st.rdata;
    assign ctl_rdata_valid = st.rvalid;
    assign mem_cmd = st.cmd;
    assign mem_reset_n = st.mrst_n;
    assign mem_cke = st.cke;
    assign mem_dq_out = st.dq_out;
    assign mem_dq_oe = st.dq_oe;
    assign mem_dqs_out = DQS_PATTERN;
    assign mem_dqs_oe = st.dqs_oe;
    assign data_mask_pins = st.dm;
    assign mem_rt_en = st.rt;
    assign mem_dqs_gate = st.gate;
endmodule : dph_phy_handshake

// ===== verification/dph_phy_handshake_props.sv
// Port-level assertions for the half-rate PHY handshake block
module dph_phy_handshake_props
    import dph_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic soft_reset_n,
    input wire logic ctl_clk,
    input wire logic ctl_clk_en,
    input wire logic ctl_reset_n,
    input wire logic ctl_cal_success,
    input wire logic ctl_cal_fail,
    input wire logic [LAT_W-1:0] ctl_rlat,
    input wire logic [LAT_W-1:0] ctl_wlat,
    input wire logic [2*RANKS-1:0] ctl_cs_n,
    input wire logic [2*AW-1:0] ctl_addr,
    input wire logic [1:0] ctl_doing_read,
    input wire logic [1:0] ctl_dqs_burst,
    input wire logic [1:0] ctl_rdata_valid,
    input wire dph_cmd_t mem_cmd,
    input wire logic mem_dqs_oe,
    input wire logic mem_rt_en
);
    default clocking @(posedge clk_sys); endclocking
    // Soft reset aborts any transfer in flight, so it disables too
    default disable iff (!rst_n || !soft_reset_n);
    logic go;
    assign go = ctl_cal_success && ctl_clk_en;

    AST_CLK_TOGGLE: assert property (
        ctl_reset_n && $past(ctl_reset_n) |-> ctl_clk != $past(ctl_clk))
        else $error("interface clock did not toggle");
    AST_RESET_HOLD: assert property (disable iff (1'b0)
        !rst_n |=> !ctl_reset_n && !ctl_cal_success)
        else $error("reset not applied");
    AST_RST_SYNC: assert property (
        $rose(ctl_reset_n) |-> $past(ctl_clk_en))
        else $error("user reset released off the interface edge");
    AST_CAL_EXCL: assert property (!(ctl_cal_success && ctl_cal_fail))
        else $error("success and failure together");
    AST_SOFT_CLEAR: assert property (disable iff (!rst_n)
        !soft_reset_n |=> !ctl_cal_success && !ctl_cal_fail)
        else $error("status kept under soft reset");
    AST_LAT_HOLD: assert property (
        ctl_cal_success && $past(ctl_cal_success) |-> $stable(ctl_rlat) && $stable(ctl_wlat))
        else $error("latency changed in operation");
    AST_LAT_SET: assert property (
        $rose(ctl_cal_success) |-> ctl_rlat != 5'h00 && ctl_wlat == WLAT_BASE)
        else $error("latencies not set at success");
    AST_CS_ORDER: assert property (go |=>
        mem_cmd.cs_n == {$past(ctl_cs_n[2]), $past(ctl_cs_n[0])}
        ##1 mem_cmd.cs_n == {$past(ctl_cs_n[3], 2), $past(ctl_cs_n[1], 2)})
        else $error("chip select order");
    AST_ADDR_HALF: assert property (go |=>
        mem_cmd.addr == $past(ctl_addr[AW-1:0])
        ##1 mem_cmd.addr == $past(ctl_addr[2*AW-1:AW], 2))
        else $error("address halves order");
    AST_DQS_ORDER: assert property (go |=>
        mem_dqs_oe == $past(ctl_dqs_burst[0]) ##1 mem_dqs_oe == $past(ctl_dqs_burst[1], 2))
        else $error("strobe burst order");
    AST_RT_FOLLOW: assert property (go |=>
        mem_rt_en == $past(ctl_doing_read[0]) ##1 mem_rt_en == $past(ctl_doing_read[1], 2))
        else $error("termination not following read");

    cover property ($rose(ctl_cal_success));
    cover property ($rose(ctl_cal_fail));
    cover property (ctl_rdata_valid == 2'h3);
endmodule : dph_phy_handshake_props

// ===== verification/dph_mem_model.sv
// Memory-side model: echoes a read strobe a fixed delay after each read
module dph_mem_model
    import dph_pkg::*;
#(
    parameter int DLY = 4,
    parameter logic [2*DQ_W-1:0] WORD = 16'h5ac3
)
(
    input wire logic clk_sys,
    input wire logic mute,
    input wire dph_cmd_t mem_cmd,
    output logic [2*DQ_W-1:0] mem_dq_in,
    output logic mem_dqs_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pipe = 16'h0000;
    always @(posedge clk_sys) begin
        pipe <= {pipe[14:0], !mute && !mem_cmd.cas_n && mem_cmd.we_n && !(&mem_cmd.cs_n)};
    end
    // Strobe burst spans two cycles; the pin filter drops anything shorter
    assign mem_dqs_in = pipe[DLY] | pipe[DLY+1];
    // Read word held steady so that it settles through the pin filter
    assign mem_dq_in = WORD;
endmodule : dph_mem_model

// ===== verification/dph_phy_handshake_tb.sv
// Self-checking bench for the half-rate PHY handshake block
module dph_phy_handshake_tb
    import dph_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2*DQ_W-1:0] RD_WORD = 16'h5ac3;
    logic clk_sys = 1'b0, rst_n = 1'b0, soft_reset_n = 1'b1, mute = 1'b0;
    logic ctl_clk, ctl_clk_en, ctl_reset_n, ctl_cal_success, ctl_cal_fail;
    logic [LAT_W-1:0] ctl_rlat, ctl_wlat, rlat0;
    logic [2*RANKS-1:0] ctl_cs_n = 4'hf;
    logic [1:0] ctl_ras_n = 2'h3, ctl_cas_n = 2'h3, ctl_we_n = 2'h3, ctl_rdata_valid;
    logic [2*AW-1:0] ctl_addr = '0;
    logic [2*BW-1:0] ctl_ba = 6'h09;
    logic [1:0] ctl_doing_read = '0, ctl_dqs_burst = '0, ctl_wdata_valid = '0;
    logic [4*DQ_W-1:0] ctl_wdata = '0, ctl_rdata;
    logic [4*DM_W-1:0] ctl_dm = '0;
    dph_cmd_t mem_cmd, lo_cmd, hi_cmd;
    logic mem_reset_n, mem_cke, mem_dq_oe, mem_dqs_oe, mem_dqs_in, mem_rt_en, mem_dqs_gate;
    logic [2*DQ_W-1:0] mem_dq_out, mem_dq_in, lo_dq, hi_dq;
    logic [1:0] mem_dqs_out, data_mask_pins;
    logic [7:0] lo_x, hi_x;
    wire [7:0] now_x = {mem_dqs_gate, ctl_rdata_valid, mem_dq_oe, mem_dqs_oe, mem_rt_en,
                        data_mask_pins};
    int miscompares = 0, comparisons = 0;

    always #2.5 clk_sys = ~clk_sys;

    dph_phy_handshake dut (.clk_sys, .rst_n, .soft_reset_n, .ctl_clk, .ctl_clk_en, .ctl_reset_n,
        .ctl_cal_success, .ctl_cal_fail, .ctl_rlat, .ctl_wlat, .ctl_cs_n, .ctl_ras_n, .ctl_cas_n,
        .ctl_we_n, .ctl_addr, .ctl_ba, .ctl_doing_read, .ctl_dqs_burst, .ctl_wdata_valid,
        .ctl_wdata, .ctl_dm, .ctl_rdata, .ctl_rdata_valid, .mem_cmd, .mem_reset_n, .mem_cke,
        .mem_dq_out, .mem_dq_oe, .mem_dq_in, .mem_dqs_out, .mem_dqs_oe, .mem_dqs_in,
        .data_mask_pins, .mem_rt_en, .mem_dqs_gate);
    dph_mem_model #(.DLY(4), .WORD(RD_WORD)) u_mem (.clk_sys, .mute, .mem_cmd, .mem_dq_in,
        .mem_dqs_in);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic next_en;
        do tick; while (ctl_clk_en !== 1'b1);
    endtask : next_en
    task automatic wait_cal(input int n);
        for (int i = 0; i < n && !ctl_cal_success && !ctl_cal_fail; i++) tick;
    endtask : wait_cal
    // One interface cycle: both memory-cycle halves are captured for judging
    task automatic beat(input logic [3:0] cs, input logic [5:0] rcw, input logic [27:0] a,
                        input logic [5:0] rdw, input logic [31:0] wd, input logic [3:0] dm);
        {ctl_cs_n, ctl_addr, ctl_wdata, ctl_dm} = {cs, a, wd, dm};
        {ctl_ras_n, ctl_cas_n, ctl_we_n} = rcw;
        {ctl_doing_read, ctl_dqs_burst, ctl_wdata_valid} = rdw;
        tick;
        lo_cmd = mem_cmd;
        lo_dq = mem_dq_out;
        lo_x = now_x;
        tick;
        hi_cmd = mem_cmd;
        hi_dq = mem_dq_out;
        hi_x = now_x;
    endtask : beat
    task automatic idle;
        beat(4'hf, 6'h3f, 28'h0, 6'h00, 32'h0, 4'h0);
    endtask : idle

    task automatic t_boot;
        rst_n = 1'b0;
        repeat (12) tick;
        check({ctl_reset_n, ctl_cal_success, mem_cke}, 3'h0, "outputs not in reset");
        rst_n = 1'b1;
        wait_cal(3000);
        check({mem_reset_n, mem_cke, ctl_reset_n}, 3'h7, "init not complete");
        check({ctl_cal_success, ctl_cal_fail}, 2'h2, "calibration outcome");
        check(ctl_wlat, WLAT_BASE, "write latency");
        check(ctl_rlat != 5'h00, 1'b1, "read latency unset");
        rlat0 = ctl_rlat;
        $display("test boot done");
    endtask : t_boot

    task automatic t_write;
        next_en;
        beat(4'hc, 6'h0f, {14'h1555, 14'h1555}, 6'h00, 32'h0, 4'h0);
        check(lo_cmd, {2'h2, 3'h3, 14'h1555, 3'h1}, "2T first half");
        check(hi_cmd, {2'h2, 3'h3, 14'h1555, 3'h1}, "2T second half");
        beat(4'hd, 6'h35, {14'h0123, 14'h2abc}, 6'h00, 32'h0, 4'h0);
        check(lo_cmd, {2'h3, 3'h7, 14'h2abc, 3'h1}, "write low half");
        check(hi_cmd, {2'h2, 3'h4, 14'h0123, 3'h1}, "write high half");
        // Strobe leads write data by one memory cycle
        beat(4'hf, 6'h3f, 28'h0, 6'h08, 32'h0, 4'h0);
        check({lo_x[4], hi_x[4], lo_x[3], hi_x[3]}, 4'h1, "strobe lead");
        beat(4'hf, 6'h3f, 28'h0, 6'h0f, 32'hdeadbeef, 4'h6);
        check({lo_dq, hi_dq}, 32'hbeefdead, "write data order");
        check({lo_x[4:3], lo_x[1:0], hi_x[4:3], hi_x[1:0]}, 8'hed, "partial mask");
        // Low half invalid: data pins released, strobe kept running
        beat(4'hf, 6'h3f, 28'h0, 6'h0e, 32'h0, 4'h0);
        check({lo_x[4], hi_x[4], lo_x[3], hi_x[3]}, 4'h7, "write valid drop");
        check(mem_dqs_out, DQS_PATTERN, "strobe pattern");
        idle;
        $display("test write done");
    endtask : t_write

    task automatic t_read;
        int k;
        next_en;
        // Read flag opens a memory cycle before chip select
        beat(4'hd, 6'h37, 28'h0, 6'h30, 32'h0, 4'h0);
        check({lo_x[2], hi_x[2]}, 2'h3, "termination follows read");
        beat(4'hf, 6'h3f, 28'h0, 6'h30, 32'h0, 4'h0);
        k = 1;
        while (k < 30 && lo_x[6:5] === 2'h0) begin
            idle;
            k++;
        end
        check(k, ctl_rlat, "read valid delay");
        check(lo_x[6:5], 2'h3, "read valid lanes");
        check({lo_x[7], hi_x[7]}, 2'h3, "postamble gate");
        check(ctl_rdata, {2{RD_WORD}}, "read data lanes");
        idle;
        check(lo_x[6:5], 2'h3, "second read cycle");
        idle;
        check(lo_x[6:5], 2'h0, "read valid end");
        $display("test read done");
    endtask : t_read

    task automatic t_recal;
        mute = 1'b1;
        soft_reset_n = 1'b0;
        repeat (4) tick;
        check({ctl_cal_success, ctl_cal_fail}, 2'h0, "status not cleared");
        soft_reset_n = 1'b1;
        wait_cal(RANKS * 80);
        check({ctl_cal_success, ctl_cal_fail}, 2'h1, "missing strobe passed");
        mute = 1'b0;
        soft_reset_n = 1'b0;
        tick;
        soft_reset_n = 1'b1;
        wait_cal(RANKS * 80);
        check({ctl_cal_success, ctl_cal_fail}, 2'h2, "recalibration");
        check(ctl_rlat, rlat0, "read latency changed");
        $display("test recal done");
    endtask : t_recal

    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    initial begin
        t_boot;
        t_write;
        t_read;
        t_recal;
        t_boot;
        give_verdict;
    end
    // Two boots with memory init, two recalibrations and traffic stay far below this span
    initial begin
        #60us;
        miscompares++;
        give_verdict;
    end
endmodule : dph_phy_handshake_tb

bind dph_phy_handshake dph_phy_handshake_props u_props (.clk_sys, .rst_n, .soft_reset_n,
    .ctl_clk, .ctl_clk_en, .ctl_reset_n, .ctl_cal_success, .ctl_cal_fail, .ctl_rlat, .ctl_wlat,
    .ctl_cs_n, .ctl_addr, .ctl_doing_read, .ctl_dqs_burst, .ctl_rdata_valid, .mem_cmd,
    .mem_dqs_oe, .mem_rt_en);
